/* File: cks_defines.svh */
`ifndef CKS_DEFINES_SVH
`define CKS_DEFINES_SVH
// startup step lengths, in reference or feedback ticks
`define CKS_REF_CYCLES   65536
`define CKS_FB_CYCLES    65536
`define CKS_CAL_CYCLES   131072
// lock indication delay after calibration, inside 2048..2560
`define CKS_LOCK_CYCLES  2305
`define CKS_LOCK_MIN     2048
`define CKS_LOCK_MAX     2560
`define CKS_CNT_W        18
`define CKS_CFG_W        8
`define CKS_CFG_DEFAULT  8'h00
`define CKS_N_OUT        8
`define CKS_SYNC_W       2
`endif

/* File: cks_host_model.sv */
`timescale 1ns/1ps
module cks_host_model (
   // clock
   input  wire logic       core_clk_i,
   // device pins and register bits
   output logic            rst_low_o,
   output logic            pdn_low_o,
   output logic            si_mode_o,
   output logic            sw_reset_o,
   output logic            we_o,
   output logic [7:0]      data_o
);
   initial begin
      rst_low_o  = 1'b1;
      pdn_low_o  = 1'b1;
      si_mode_o  = 1'b0;
      sw_reset_o = 1'b0;
      we_o       = 1'b0;
      data_o     = 8'h00;
   end
   // pin changes land just after a falling edge
   task automatic set_pins(input logic rst_low, input logic pdn_low, input logic si);
      @(negedge core_clk_i);
      rst_low_o = rst_low;
      pdn_low_o = pdn_low;
      si_mode_o = si;
   endtask
   task automatic set_sw_reset(input logic v);
      @(negedge core_clk_i);
      sw_reset_o = v;
   endtask
   // reset pin stays high while a write is in flight
   task automatic write_cfg(input logic [7:0] d);
      @(negedge core_clk_i);
      we_o   = 1'b1;
      data_o = d;
      @(negedge core_clk_i);
      we_o   = 1'b0;
      data_o = ~d;
   endtask
endmodule

/* File: cks_pkg.sv */
package cks_pkg;
   typedef enum logic [5:0] {
      CKS_RAMP   = 6'h01,
      CKS_XO     = 6'h02,
      CKS_REFCNT = 6'h04,
      CKS_FBCNT  = 6'h08,
      CKS_CAL    = 6'h10,
      CKS_RUN    = 6'h20
   } cks_state_t;
   typedef enum logic {
      CKS_MODE_PIN    = 1'b0,
      CKS_MODE_SERIAL = 1'b1
   } cks_mode_t;
endpackage

/* File: cks_seq.sv */
`timescale 1ns/1ps
`include "cks_defines.svh"
module cks_seq #(
   parameter int REF_CYCLES  = `CKS_REF_CYCLES,
   parameter int FB_CYCLES   = `CKS_FB_CYCLES,
   parameter int CAL_CYCLES  = `CKS_CAL_CYCLES,
   parameter int LOCK_CYCLES = `CKS_LOCK_CYCLES,
   parameter int N_OUT       = `CKS_N_OUT,
   parameter int CFG_W       = `CKS_CFG_W
) (
   // clock and power-on reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   // device pins, asynchronous
   input  wire logic             chip_reset_low_i,
   input  wire logic             power_down_pin_low_i,
   input  wire logic             si_mode_i,
   input  wire logic             xtal_amp_ok_i,
   input  wire logic [CFG_W-1:0] cfg_pins_i,
   // internal, same clock
   input  wire logic             xtal_used_i,
   input  wire logic             pfd_tick_i,
   input  wire logic             fb_tick_i,
   input  wire logic             sw_reset_i,
   input  wire logic             host_cfg_we_i,
   input  wire logic [CFG_W-1:0] host_cfg_data_i,
   input  wire logic             lock_route_i,
   // outputs
   output logic [N_OUT-1:0]      out_en_o,
   output logic                  power_down_o,
   output logic                  cal_busy_o,
   output logic                  status_output_zero_o,
   output logic                  status_output_one_o,
   output cks_pkg::cks_mode_t    mode_o,
   output logic [CFG_W-1:0]      cfg_o,
   output cks_pkg::cks_state_t   state_o
);
   import cks_pkg::*;

   localparam int SW = CFG_W + 4;

   generate
      if (REF_CYCLES < 1 || FB_CYCLES < 1 || CAL_CYCLES < 1 || LOCK_CYCLES < 1
          || CAL_CYCLES > (1 << `CKS_CNT_W) || REF_CYCLES > (1 << `CKS_CNT_W)
          || FB_CYCLES > (1 << `CKS_CNT_W) || LOCK_CYCLES > (1 << `CKS_CNT_W)
          || N_OUT < 1 || CFG_W < 1) begin : g_chk
         $error("cks_seq: unsupported parameter value");
      end
   endgenerate

   // two-flop synchronisers for every pin
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] sync_a;
   logic [SW-1:0] sync_b;
   assign pin_raw = {chip_reset_low_i, power_down_pin_low_i, si_mode_i, xtal_amp_ok_i,
                     cfg_pins_i};

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= pin_raw;
         sync_b <= sync_a;
      end
   end

   logic             rst_pin_s;
   logic             pdn_s;
   logic             si_mode_s;
   logic             xo_ok_s;
   logic [CFG_W-1:0] cfg_pins_s;
   assign {rst_pin_s, pdn_s, si_mode_s, xo_ok_s, cfg_pins_s} = sync_b;

   cks_mode_t  mode;
   cks_state_t state;
   cks_state_t next_state;
   logic       init_pending;
   logic       reset_evt;
   logic       run_ok;
   logic       lock;

   // a low reset pin is a reset event in both modes and also a power input in pin mode
   assign reset_evt = !rst_pin_s || sw_reset_i || init_pending;
   assign run_ok = rst_pin_s && pdn_s
                   && !(sw_reset_i && mode == CKS_MODE_SERIAL);

   // power-up reset event lasts until the pin synchronisers have filled, so the
   // interface-select level caught at power-up is the real one
   logic [`CKS_SYNC_W:0] init_sr;
   assign init_pending = init_sr[0];
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         init_sr <= '1;
      end else begin
         init_sr <= {1'b0, init_sr[`CKS_SYNC_W:1]};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode <= CKS_MODE_PIN;
      end else if (reset_evt) begin
         mode <= cks_mode_t'(si_mode_s);
      end
   end

   // configuration source
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg_o <= `CKS_CFG_DEFAULT;
      end else if (mode == CKS_MODE_PIN) begin
         cfg_o <= cfg_pins_s;
      end else if (reset_evt) begin
         cfg_o <= `CKS_CFG_DEFAULT;
      end else if (host_cfg_we_i) begin
         cfg_o <= host_cfg_data_i;
      end
   end

   // step timer
   cks_tmr_if #(.W(`CKS_CNT_W)) tmr ();

   cks_timer #(.W(`CKS_CNT_W)) u_timer (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .t          (tmr.timer)
   );

   assign tmr.clr = (state == CKS_RAMP) || (state == CKS_XO) || !run_ok;

   always_comb begin
      tmr.tick   = pfd_tick_i;
      tmr.target = `CKS_CNT_W'(REF_CYCLES);
      unique case (state)
         CKS_FBCNT: begin
            tmr.tick   = fb_tick_i;
            tmr.target = `CKS_CNT_W'(FB_CYCLES);
         end
         CKS_CAL: tmr.target = `CKS_CNT_W'(CAL_CYCLES);
         CKS_RUN: tmr.target = `CKS_CNT_W'(LOCK_CYCLES);
         default: tmr.target = `CKS_CNT_W'(REF_CYCLES);
      endcase
   end

   // startup sequence
   always_comb begin
      next_state = state;
      unique case (state)
         CKS_RAMP: if (run_ok) begin
            next_state = xtal_used_i ? CKS_XO : CKS_REFCNT;
         end
         CKS_XO: if (xo_ok_s) begin
            next_state = CKS_REFCNT;
         end
         CKS_REFCNT: if (tmr.done) begin
            next_state = CKS_FBCNT;
         end
         CKS_FBCNT: if (tmr.done) begin
            next_state = CKS_CAL;
         end
         CKS_CAL: if (tmr.done) begin
            next_state = CKS_RUN;
         end
         CKS_RUN: next_state = CKS_RUN;
         default: next_state = CKS_RAMP;
      endcase
      if (!run_ok) begin
         next_state = CKS_RAMP;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state <= CKS_RAMP;
      end else begin
         state <= next_state;
      end
   end

   // lock rises when the timer first expires in the run state
   always_ff @(posedge core_clk_i) begin
      if (rst_i || state != CKS_RUN || !run_ok) begin
         lock <= 1'b0;
      end else if (tmr.done) begin
         lock <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         out_en_o             <= '0;
         power_down_o         <= 1'b1;
         cal_busy_o           <= 1'b0;
         status_output_zero_o <= 1'b0;
         status_output_one_o  <= 1'b0;
         mode_o               <= CKS_MODE_PIN;
         state_o              <= CKS_RAMP;
      end else begin
         out_en_o     <= {N_OUT{state == CKS_RUN && run_ok}};
         power_down_o <= !pdn_s || (mode == CKS_MODE_PIN && !rst_pin_s);
         cal_busy_o   <= (state == CKS_CAL);
         status_output_zero_o <= lock && lock_route_i;
         status_output_one_o  <= (state == CKS_RUN);
         mode_o       <= mode;
         state_o      <= state;
      end
   end

   // lock delay measured from entry to run
   logic [`CKS_CNT_W-1:0] run_cnt;
   always_ff @(posedge core_clk_i) begin
      if (rst_i || state != CKS_RUN) begin
         run_cnt <= '0;
      end else if (pfd_tick_i && !lock) begin
         run_cnt <= run_cnt + `CKS_CNT_W'(1);
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_pin_cfg: assert property (mode == CKS_MODE_PIN && $past(mode) == CKS_MODE_PIN
      |=> cfg_o == $past(cfg_pins_s)) else $error("pin mode cfg mismatch");
   a_prog_default: assert property (mode == CKS_MODE_SERIAL && reset_evt
      |=> cfg_o == `CKS_CFG_DEFAULT) else $error("default not loaded");
   a_mode_adopt: assert property (reset_evt
      |=> mode == $past(si_mode_s)) else $error("mode not adopted on reset");
   a_out_off_reset: assert property (!run_ok
      |=> out_en_o == '0) else $error("outputs on during reset");
   a_pin_power: assert property (mode == CKS_MODE_PIN && !rst_pin_s
      |=> power_down_o) else $error("power input ignored");
   a_reset_hold: assert property (!rst_pin_s [*2]
      |-> out_en_o == '0 && state == CKS_RAMP) else $error("output during hold");
   a_auto_start: assert property (state == CKS_RAMP && run_ok && !xtal_used_i
      |=> state == CKS_REFCNT) else $error("no automatic start");
   a_pd_mode: assert property (!pdn_s
      |=> power_down_o && out_en_o == '0) else $error("power-down ignored");
   a_ramp_hold: assert property (state == CKS_RAMP && !run_ok
      |=> state == CKS_RAMP) else $error("left ramp while held");
   a_xo_wait: assert property (state == CKS_XO && !xo_ok_s
      |=> state == CKS_XO || state == CKS_RAMP) else $error("xtal not awaited");
   a_ref_before: assert property ($rose(state == CKS_FBCNT)
      |-> $past(state) == CKS_REFCNT) else $error("feedback step out of order");
   a_cal_after_fb: assert property ($rose(state == CKS_CAL)
      |-> $past(state) == CKS_FBCNT) else $error("calibration out of order");
   a_cal_end: assert property (state == CKS_CAL && tmr.done && run_ok
      |=> state == CKS_RUN ##1 (out_en_o != '0 || !$past(run_ok)))
      else $error("outputs late after calibration");
   a_lock_time: assert property ($rose(lock)
      |-> run_cnt >= `CKS_CNT_W'(LOCK_CYCLES) - `CKS_CNT_W'(1)
          && run_cnt <= `CKS_CNT_W'(LOCK_CYCLES))
      else $error("lock delay wrong");
   a_restart: assert property (!run_ok
      |=> state == CKS_RAMP) else $error("no restart on reset");

   c_full_start: cover property ($rose(state == CKS_RUN));
   c_lock_seen:  cover property ($rose(status_output_zero_o));
   c_abort_cal:  cover property (state == CKS_CAL && !run_ok);
   c_xtal_path:  cover property (state == CKS_XO ##1 state == CKS_REFCNT);
endmodule

/* File: cks_timer.sv */
`timescale 1ns/1ps
module cks_timer #(
   parameter int W = 18
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   cks_tmr_if.timer t
);
   logic [W-1:0] cnt;
   logic         at_end;

   assign at_end = (cnt == t.target - W'(1));
   assign t.done = t.tick && at_end && !t.clr;

   // counts ticks and wraps to zero on the last one
   always_ff @(posedge core_clk_i) begin
      if (rst_i || t.clr) begin
         cnt <= '0;
      end else if (t.tick) begin
         cnt <= at_end ? '0 : cnt + W'(1);
      end
   end

   a_timer_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
      t.done |=> cnt == '0)
      else $error("timer did not wrap after done");
endmodule

/* File: cks_tmr_if.sv */
`timescale 1ns/1ps
interface cks_tmr_if #(parameter int W = 18);
   logic         clr;
   logic         tick;
   logic [W-1:0] target;
   logic         done;
   modport ctrl  (output clr, output tick, output target, input done);
   modport timer (input clr, input tick, input target, output done);
endinterface

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   import cks_pkg::*;
   localparam int REF = 8;
   localparam int FB = 8;
   localparam int CAL = 16;
   localparam int LOCK = 10;
   logic       core_clk_i = 1'b0;
   logic       rst_i      = 1'b1;
   logic       rst_low, pdn_low, si_mode, sw_reset, we;
   logic [7:0] data;
   logic       amp_ok     = 1'b0;
   logic       xtal_used  = 1'b0;
   logic       pfd_tick   = 1'b0;
   logic       fb_tick    = 1'b0;
   logic       pfd_q      = 1'b0;
   logic       fb_q       = 1'b0;
   logic       lock_route = 1'b1;
   logic [7:0] cfg_pins   = 8'h00;
   logic [7:0] out_en, cfg, en_seen, d;
   logic       power_down, cal_busy, st0, st1;
   cks_mode_t  mode;
   cks_state_t state;
   int         error_cnt = 0;
   int         tests_run = 0;
   int         n_ref, n_fb, n_cal, n_lock;
   always #5 core_clk_i = ~core_clk_i;
   cks_host_model u_host (.core_clk_i(core_clk_i), .rst_low_o(rst_low), .pdn_low_o(pdn_low),
      .si_mode_o(si_mode), .sw_reset_o(sw_reset), .we_o(we), .data_o(data));
   cks_seq #(.REF_CYCLES(REF), .FB_CYCLES(FB), .CAL_CYCLES(CAL), .LOCK_CYCLES(LOCK)) u_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .chip_reset_low_i(rst_low),
      .power_down_pin_low_i(pdn_low), .si_mode_i(si_mode), .xtal_amp_ok_i(amp_ok),
      .cfg_pins_i(cfg_pins), .xtal_used_i(xtal_used), .pfd_tick_i(pfd_tick),
      .fb_tick_i(fb_tick), .sw_reset_i(sw_reset), .host_cfg_we_i(we), .host_cfg_data_i(data),
      .lock_route_i(lock_route), .out_en_o(out_en), .power_down_o(power_down),
      .cal_busy_o(cal_busy),
      .status_output_zero_o(st0), .status_output_one_o(st1), .mode_o(mode), .cfg_o(cfg),
      .state_o(state));
   always @(negedge core_clk_i) begin
      pfd_tick = ($urandom % 3) != 0;
      fb_tick  = ($urandom % 2) != 0;
   end
   // tick counts per startup step; ticks are delayed one cycle to line up with the
   // registered state view, and every return to ramp starts the counts afresh
   always @(posedge core_clk_i) begin
      if (state === CKS_RAMP || state === CKS_XO) begin
         n_ref = 0;
         n_fb = 0;
         n_cal = 0;
         n_lock = 0;
         en_seen = 8'h00;
      end
      if (pfd_q && state === CKS_REFCNT) n_ref++;
      if (fb_q && state === CKS_FBCNT) n_fb++;
      if (pfd_q && state === CKS_CAL) n_cal++;
      if (pfd_q && state === CKS_RUN && st0 !== 1'b1) n_lock++;
      if (state === CKS_REFCNT || state === CKS_FBCNT || state === CKS_CAL) en_seen |= out_en;
      pfd_q = pfd_tick;
      fb_q = fb_tick;
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wait_state(input cks_state_t s, input int lim);
      for (int i = 0; i < lim && state !== s; i++) @(negedge core_clk_i);
      if (state !== s) begin
         check("state wait", state, s);
         test_done();
      end
   endtask
   // full startup with no command after release
   task automatic bring_up(input string name);
      wait_state(CKS_CAL, 200);
      repeat (2) @(negedge core_clk_i);
      check("cal busy", cal_busy, 1'b1);
      wait_state(CKS_RUN, 200);
      check("ref ticks", n_ref, REF);
      check("fb ticks", n_fb, FB);
      check("cal ticks", n_cal, CAL);
      check("early enables", en_seen, 8'h00);
      repeat (2) @(negedge core_clk_i);
      check("enables on", out_en, 8'hFF);
      check("run status", st1, 1'b1);
      for (int i = 0; i < 100 && st0 !== 1'b1; i++) @(negedge core_clk_i);
      check("lock status", st0, 1'b1);
      check("lock ticks", n_lock, LOCK);
      $display("test %s done", name);
   endtask
   initial begin
      void'($urandom(75685));
      cfg_pins = $urandom;
      repeat (6) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      check("mode", mode, CKS_MODE_PIN);
      check("pin cfg", cfg, cfg_pins);
      u_host.write_cfg(~cfg_pins);
      check("pin cfg kept", cfg, cfg_pins);
      bring_up("pin startup");
      u_host.set_pins(1'b0, 1'b1, 1'b0);
      repeat (4) @(negedge core_clk_i);
      check("power input", power_down, 1'b1);
      u_host.set_pins(1'b0, 1'b1, 1'b1);
      repeat (30) @(negedge core_clk_i);
      check("held enables", out_en, 8'h00);
      check("held state", state, CKS_RAMP);
      u_host.set_pins(1'b1, 1'b1, 1'b1);
      repeat (4) @(negedge core_clk_i);
      check("mode", mode, CKS_MODE_SERIAL);
      check("default cfg", cfg, 8'h00);
      repeat (4) begin
         d = $urandom;
         u_host.write_cfg(d);
         check("host cfg", cfg, d);
      end
      bring_up("serial startup");
      u_host.set_sw_reset(1'b1);
      repeat (3) @(negedge core_clk_i);
      check("sw reset enables", out_en, 8'h00);
      check("sw reset cfg", cfg, 8'h00);
      repeat (20) @(negedge core_clk_i);
      check("sw reset state", state, CKS_RAMP);
      u_host.set_sw_reset(1'b0);
      wait_state(CKS_CAL, 200);
      u_host.set_pins(1'b1, 1'b0, 1'b1);
      repeat (4) @(negedge core_clk_i);
      check("power down", power_down, 1'b1);
      check("abort enables", out_en, 8'h00);
      check("abort state", state, CKS_RAMP);
      u_host.set_pins(1'b1, 1'b1, 1'b1);
      bring_up("restart");
      xtal_used = 1'b1;
      u_host.set_pins(1'b0, 1'b1, 1'b1);
      u_host.set_pins(1'b1, 1'b1, 1'b1);
      repeat (30) @(negedge core_clk_i);
      check("crystal wait", state, CKS_XO);
      amp_ok = 1'b1;
      bring_up("crystal startup");
      lock_route = 1'b0;
      repeat (2) @(negedge core_clk_i);
      check("lock unrouted", st0, 1'b0);
      test_done();
   end
endmodule
